// >>> hw/vsc_pkg.sv
// constants and types shared by the sync, clamp and coast control block
package vsc_pkg;
  // two-bit polarity settings: 0x = automatic, 10 = active low, 11 = active high
  localparam logic [1:0] POL_AUTO_LO = 2'h0;
  localparam logic [1:0] POL_AUTO_HI = 2'h1;
  localparam logic [1:0] POL_LOW = 2'h2;
  localparam logic [1:0] POL_HIGH = 2'h3;
  localparam logic [1:0] VPOL_RESET = 2'h0;
  localparam logic [1:0] CLPOL_RESET = 2'h0;
  localparam logic [1:0] COAST_POL_RESET = 2'h3;
  localparam logic CLAMP_EXT_RESET = 1'h0;
  // slicer threshold code n means (n+1)*8 mV, 8..256 mV
  localparam int SOG_STEP_MV = 8;
  localparam int SOG_MIN_MV = 8;
  localparam int SOG_MAX_MV = 256;
  localparam int SOG_RESET_MV = 128;
  localparam logic [4:0] SOG_RESET_CODE = 5'((SOG_RESET_MV - SOG_MIN_MV) / SOG_STEP_MV);
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    VSC_CL_IDLE = 3'h1,
    VSC_CL_DELAY = 3'h2,
    VSC_CL_ON = 3'h4
  } vsc_clamp_state_t;
endpackage

// >>> hw/vsc_pol_if.sv
// interface between the top and its polarity resolver
interface vsc_pol_if;
  logic ce;
  logic raw;
  logic [1:0] pol;
  logic active;
  logic active_high;
  modport top (output ce, raw, pol, input active, active_high);
  modport res (input ce, raw, pol, output active, active_high);
endinterface

// >>> hw/vsc_pol_resolve.sv
// polarity resolver: manual or automatic sense of one sync input
module vsc_pol_resolve
(
  input wire logic clock_in,
  input wire logic rst_in,
  vsc_pol_if.res p
);
  logic [vsc_pkg::CNT_W-1:0] hi_cnt, lo_cnt, next_hi_cnt, next_lo_cnt;
  logic auto_hi, next_auto_hi, prev, next_prev;

  always_comb
  begin
    next_hi_cnt = hi_cnt;
    next_lo_cnt = lo_cnt;
    next_auto_hi = auto_hi;
    next_prev = p.raw;
    // a period ends on each rising edge; the shorter level is the active one
    if (p.raw && !prev)
    begin
      next_auto_hi = hi_cnt < lo_cnt; // R16
      next_hi_cnt = '0;
      next_lo_cnt = '0;
    end
    else if (p.raw)
    begin
      if (~&hi_cnt)
        next_hi_cnt = hi_cnt + 1'b1;
    end
    else if (~&lo_cnt)
      next_lo_cnt = lo_cnt + 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      auto_hi <= 1'b1;
      prev <= 1'b0;
    end
    else if (p.ce)
    begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      auto_hi <= next_auto_hi;
      prev <= next_prev;
    end
  end

  assign p.active_high = p.pol[1] ? p.pol[0] : auto_hi;
  assign p.active = p.raw ~^ p.active_high; // R16
endmodule

// >>> hw/vsc_top.sv
// sync, clamp, coast and power-down control of the capture front end
// Behaviour
// R1: vertical sync drives field and coast timing; code: coast from coast pin only
// R2: vertical polarity automatic or manual two-bit
// R3: slicer threshold 8-256 mV, 8 mV steps, 128
// R4: slicer output is comparator result, non-inverted
// R5: clamp pin marks clamp interval when enabled
// R6: clamp pin honoured only when source bit set
// R7: otherwise count delay then duration after trailing
// R8: clamp polarity automatic or manual two-bit
// R9: external clock replaces PLL clock when selected
// R10: coast freezes pixel clock frequency and phase
// R11: coast polarity automatic or manual, resets high
// R12: external clock and coast stay independent
// R13: power-down pin used only in manual mode
// R14: unused pin: polarity high, tie low
// R15: hsync polarity picks leading and trailing edges
// R16: auto polarity from shorter level duration
module vsc_top
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic horizontal_sync_input_0_in,
  input wire logic vertical_sync_input_0_in,
  input wire logic vertical_sync_input_1_in,
  input wire logic vsync_select_in,
  input wire logic clamp_pin_in,
  input wire logic coast_pin_in,
  input wire logic power_down_pin_in,
  input wire logic sog_compare_in,
  input wire logic [1:0] hsync_pol_in,
  input wire logic [1:0] vsync_pol_in,
  input wire logic [1:0] clamp_pol_in,
  input wire logic [1:0] coast_pol_in,
  input wire logic clamp_ext_en_in,
  input wire logic ext_clock_en_in,
  input wire logic manual_pd_en_in,
  input wire logic pd_pin_active_high_in,
  input wire logic [4:0] sog_threshold_in,
  input wire logic [vsc_pkg::CNT_W-1:0] clamp_delay_in,
  input wire logic [vsc_pkg::CNT_W-1:0] clamp_width_in,
  output logic clamp_out,
  output logic coast_out,
  output logic ext_clock_sel_out,
  output logic power_down_out,
  output logic sync_slicer_output_out,
  output logic [4:0] sog_threshold_out,
  output logic field_odd_out,
  output logic vsync_leading_out
);
  // two-stage synchronisers; stage one feeds stage two only
  logic [6:0] sync1, sync2;
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (clk_en_in)
    begin
      sync1 <= {sog_compare_in, power_down_pin_in, coast_pin_in, clamp_pin_in,
                vertical_sync_input_1_in, vertical_sync_input_0_in,
                horizontal_sync_input_0_in};
      sync2 <= sync1;
    end
  end

  logic hs_s, vs_s, clamp_s, coast_s, pd_s, sog_s;
  assign hs_s = sync2[0];
  assign vs_s = vsync_select_in ? sync2[2] : sync2[1];
  assign clamp_s = sync2[3];
  assign coast_s = sync2[4];
  assign pd_s = sync2[5];
  assign sog_s = sync2[6];

  // latched settings; coast polarity defaults to active high
  logic [1:0] hpol_q, vpol_q, clpol_q, copol_q;
  logic [4:0] sog_q;
  logic [1:0] next_hpol, next_vpol, next_clpol, next_copol;
  logic [4:0] next_sog;
  always_comb
  begin
    next_hpol = hsync_pol_in;
    next_vpol = vsync_pol_in; // R2
    next_clpol = clamp_pol_in; // R8
    next_copol = coast_pol_in; // R11
    next_sog = sog_threshold_in; // R3
  end
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      hpol_q <= vsc_pkg::POL_AUTO_LO;
      vpol_q <= vsc_pkg::VPOL_RESET;
      clpol_q <= vsc_pkg::CLPOL_RESET;
      copol_q <= vsc_pkg::COAST_POL_RESET; // R11
      sog_q <= vsc_pkg::SOG_RESET_CODE; // R3
    end
    else if (clk_en_in)
    begin
      hpol_q <= next_hpol;
      vpol_q <= next_vpol;
      clpol_q <= next_clpol;
      copol_q <= next_copol;
      sog_q <= next_sog;
    end
  end

  vsc_pol_if hs_if();
  vsc_pol_if vs_if();
  vsc_pol_if cl_if();
  vsc_pol_if co_if();
  assign hs_if.ce = clk_en_in;
  assign hs_if.raw = hs_s;
  assign hs_if.pol = hpol_q;
  assign vs_if.ce = clk_en_in;
  assign vs_if.raw = vs_s;
  assign vs_if.pol = vpol_q;
  assign cl_if.ce = clk_en_in;
  assign cl_if.raw = clamp_s;
  assign cl_if.pol = clpol_q;
  assign co_if.ce = clk_en_in;
  assign co_if.raw = coast_s;
  assign co_if.pol = copol_q;

  vsc_pol_resolve u_hs (.clock_in(clock_in), .rst_in(rst_in), .p(hs_if));
  vsc_pol_resolve u_vs (.clock_in(clock_in), .rst_in(rst_in), .p(vs_if));
  vsc_pol_resolve u_cl (.clock_in(clock_in), .rst_in(rst_in), .p(cl_if));
  vsc_pol_resolve u_co (.clock_in(clock_in), .rst_in(rst_in), .p(co_if));

  // internal clamp timer, started on the hsync trailing edge
  vsc_pkg::vsc_clamp_state_t st, next_st;
  logic [vsc_pkg::CNT_W-1:0] cnt, next_cnt;
  logic hs_prev, vs_prev, field_q, next_field, int_clamp;
  logic hs_trail, vs_lead;
  // edges count only once the synchronisers hold pin values; their reset zeros fake one
  logic [2:0] settle, next_settle;
  assign hs_trail = settle[2] && hs_prev && !hs_if.active; // R15
  assign vs_lead = settle[2] && vs_if.active && !vs_prev;

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_field = field_q;
    next_settle = {settle[1:0], 1'b1};
    // field toggles per vertical leading edge; odd/even refinement is downstream
    if (vs_lead)
      next_field = !field_q; // R1
    unique case (st)
      vsc_pkg::VSC_CL_IDLE:
        if (hs_trail) // R7
        begin
          next_cnt = clamp_delay_in;
          next_st = (clamp_delay_in == '0) ? vsc_pkg::VSC_CL_ON : vsc_pkg::VSC_CL_DELAY;
          if (clamp_delay_in == '0)
            next_cnt = clamp_width_in;
        end
      vsc_pkg::VSC_CL_DELAY:
        if (cnt <= 1)
        begin
          next_st = vsc_pkg::VSC_CL_ON;
          next_cnt = clamp_width_in;
        end
        else
          next_cnt = cnt - 1'b1;
      vsc_pkg::VSC_CL_ON:
        if (cnt <= 1)
          next_st = vsc_pkg::VSC_CL_IDLE;
        else
          next_cnt = cnt - 1'b1;
      default:
        next_st = vsc_pkg::VSC_CL_IDLE;
    endcase
  end
  assign int_clamp = (st == vsc_pkg::VSC_CL_ON);

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      st <= vsc_pkg::VSC_CL_IDLE;
      cnt <= '0;
      hs_prev <= 1'b0;
      vs_prev <= 1'b0;
      field_q <= 1'b0;
      settle <= '0;
    end
    else if (clk_en_in)
    begin
      st <= next_st;
      cnt <= next_cnt;
      hs_prev <= hs_if.active;
      vs_prev <= vs_if.active;
      field_q <= next_field;
      settle <= next_settle;
    end
  end

  // output registers
  logic next_clamp, next_coast, next_extclk, next_pd;
  always_comb
  begin
    // pin clamp marks the interval only when enabled; pin ignored otherwise
    next_clamp = clamp_ext_en_in ? cl_if.active : int_clamp; // R5 R6 R7
    // coast and external clock are separate paths on purpose
    next_coast = co_if.active; // R10 R12
    next_extclk = ext_clock_en_in; // R9 R12
    next_pd = manual_pd_en_in && (pd_s == pd_pin_active_high_in); // R13
  end
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      clamp_out <= 1'b0;
      coast_out <= 1'b0;
      ext_clock_sel_out <= 1'b0;
      power_down_out <= 1'b0;
      sync_slicer_output_out <= 1'b0;
      sog_threshold_out <= vsc_pkg::SOG_RESET_CODE;
      field_odd_out <= 1'b0;
      vsync_leading_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      clamp_out <= next_clamp;
      coast_out <= next_coast;
      ext_clock_sel_out <= next_extclk;
      power_down_out <= next_pd;
      sync_slicer_output_out <= sog_s; // R4
      sog_threshold_out <= sog_q;
      field_odd_out <= next_field;
      vsync_leading_out <= vs_lead; // R1
    end
  end
endmodule

// >>> test/vsc_src_model.sv
// sync source model: hsync, vsync, back-porch clamp pin and coast pin
module vsc_src_model
(
  input wire logic clock_in,
  output logic hsync_n_out,
  output logic vsync_out,
  output logic clamp_pin_out,
  output logic coast_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // 64-cycle lines, 16 lines a frame; runs free so the counts stay periodic
  logic [9:0] t = 10'h0;
  always @(negedge clock_in)
    t <= t + 10'h1;
  assign hsync_n_out = t[5:0] >= 6'h4;
  assign vsync_out = t[9:6] == 4'h0;
  assign clamp_pin_out = t[5:2] == 4'h2;
  assign coast_pin_out = vsync_out;
endmodule

// >>> test/vsc_top_asserts.sv
// concurrent checks on the ports of the sync, clamp and coast block
module vsc_top_asserts
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic horizontal_sync_input_0_in,
  input wire logic vertical_sync_input_0_in,
  input wire logic vsync_select_in,
  input wire logic clamp_pin_in,
  input wire logic coast_pin_in,
  input wire logic clamp_ext_en_in,
  input wire logic ext_clock_en_in,
  input wire logic manual_pd_en_in,
  input wire logic [1:0] hsync_pol_in,
  input wire logic [1:0] vsync_pol_in,
  input wire logic [1:0] clamp_pol_in,
  input wire logic [1:0] coast_pol_in,
  input wire logic [4:0] sog_threshold_in,
  input wire logic [4:0] sog_threshold_out,
  input wire logic [vsc_pkg::CNT_W-1:0] clamp_delay_in,
  input wire logic [vsc_pkg::CNT_W-1:0] clamp_width_in,
  input wire logic clamp_out,
  input wire logic coast_out,
  input wire logic ext_clock_sel_out,
  input wire logic power_down_out,
  input wire logic vsync_leading_out
);
  logic [2:0] up;
  // calm waits out a clamp pulse begun under the old timer settings
  logic [2*vsc_pkg::CNT_W+2:0] cfg, cfg_q;
  logic [7:0] calm;
  assign cfg = {hsync_pol_in, clamp_ext_en_in, clamp_delay_in, clamp_width_in};
  logic hs_q;
  logic [15:0] hi, since;
  // up counts settled run cycles, so pipelines are full before checks apply
  always_ff @(posedge clock_in)
  begin
    up <= (rst_in || !clk_en_in) ? 3'h0 : up + 3'(up != 3'h7);
    hs_q <= horizontal_sync_input_0_in;
    cfg_q <= cfg;
    calm <= (up != 3'h7 || cfg_q != cfg) ? 8'h0 : calm + 8'(calm != 8'hFF);
    hi <= clamp_out ? hi + 16'h1 : 16'h0;
    since <= (hs_q != horizontal_sync_input_0_in && horizontal_sync_input_0_in != hsync_pol_in[0])
      ? 16'h0 : since + 16'(since != 16'hFFFF);
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  property p_ext_sel;
    $past(clk_en_in) && !$past(rst_in) |-> ext_clock_sel_out == $past(ext_clock_en_in);
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("ext clock select wrong");
  property p_pd_off;
    $past(clk_en_in) && !$past(rst_in) && !$past(manual_pd_en_in) |-> !power_down_out;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("power down without manual mode");
  property p_clamp_ext;
    (up == 3'h7 && clamp_ext_en_in && clamp_pol_in[1] && $stable(clamp_pin_in)
      && $stable(clamp_pol_in))[*6] |-> clamp_out == (clamp_pin_in ~^ clamp_pol_in[0]);
  endproperty
  a_clamp_ext: assert property (p_clamp_ext) else $error("clamp pin not followed");
  property p_coast;
    (up == 3'h7 && coast_pol_in[1] && $stable(coast_pin_in) && $stable(coast_pol_in))[*6]
      |-> coast_out == (coast_pin_in ~^ coast_pol_in[0]);
  endproperty
  a_coast: assert property (p_coast) else $error("coast pin not followed");
  property p_thr;
    (up == 3'h7 && $stable(sog_threshold_in))[*3] |-> sog_threshold_out == sog_threshold_in;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold code wrong");
  property p_width;
    calm == 8'hFF && !clamp_ext_en_in && $fell(clamp_out) |-> hi == clamp_width_in;
  endproperty
  a_width: assert property (p_width) else $error("internal clamp width wrong");
  property p_delay;
    calm == 8'hFF && !clamp_ext_en_in && $rose(clamp_out)
      |-> since >= clamp_delay_in + 16'h2 && since <= clamp_delay_in + 16'h6;
  endproperty
  a_delay: assert property (p_delay) else $error("internal clamp delay wrong");
  property p_vlead;
    up == 3'h7 && !vsync_select_in && vsync_pol_in == vsc_pkg::POL_HIGH
      && $rose(vertical_sync_input_0_in) |-> ##[2:5] vsync_leading_out;
  endproperty
  a_vlead: assert property (p_vlead) else $error("vsync leading pulse missing");
  c_int_clamp: cover property (!clamp_ext_en_in && $rose(clamp_out));
  c_lead: cover property (vsync_leading_out);
  c_pd: cover property (power_down_out);
endmodule
bind vsc_top vsc_top_asserts vsc_top_asserts_inst (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .clk_en_in(clk_en_in),
  .horizontal_sync_input_0_in(horizontal_sync_input_0_in),
  .vertical_sync_input_0_in(vertical_sync_input_0_in),
  .vsync_select_in(vsync_select_in),
  .clamp_pin_in(clamp_pin_in),
  .coast_pin_in(coast_pin_in),
  .clamp_ext_en_in(clamp_ext_en_in),
  .ext_clock_en_in(ext_clock_en_in),
  .manual_pd_en_in(manual_pd_en_in),
  .hsync_pol_in(hsync_pol_in),
  .vsync_pol_in(vsync_pol_in),
  .clamp_pol_in(clamp_pol_in),
  .coast_pol_in(coast_pol_in),
  .sog_threshold_in(sog_threshold_in),
  .sog_threshold_out(sog_threshold_out),
  .clamp_delay_in(clamp_delay_in),
  .clamp_width_in(clamp_width_in),
  .clamp_out(clamp_out),
  .coast_out(coast_out),
  .ext_clock_sel_out(ext_clock_sel_out),
  .power_down_out(power_down_out),
  .vsync_leading_out(vsync_leading_out));

// >>> test/vsc_top_tb.sv
// self-checking bench for the sync, clamp and coast control block
module vsc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic hs_n, vs, cl_pin, co_pin, clamp_o, coast_o, ext_o, pd_o, slice_o, field_o, lead_o, f0;
  logic vs1 = 1'b0, sog = 1'b0, pd_pin = 1'b0, pd_ah = 1'b1, man_pd = 1'b0, ext_en = 1'b0;
  logic cl_ext = 1'b0;
  logic vsel = 1'b0;
  logic [1:0] cl_pol = 2'h3, co_pol = 2'h3;
  logic [1:0] hpol = vsc_pkg::POL_LOW, vpol = vsc_pkg::POL_HIGH;
  logic [15:0] cdel = 16'h3, cwid = 16'h5;
  logic [4:0] thr = 5'h0, thr_o;
  logic [31:0] rnd = 32'h9793;
  // rows: clamp source, clamp polarity, coast polarity
  logic [4:0] rows[5] = '{5'h0F, 5'h1E, 5'h1B, 5'h11, 5'h0F};
  logic [15:0] exp_cl[4] = '{16'h50, 16'h40, 16'h3C0, 16'h40};
  logic [15:0] exp_co[5] = '{16'h40, 16'h3C0, 16'h40, 16'h40, 16'h40};
  int err_total = 0;
  int num_checks = 0;
  int c_cl, c_co;
  vsc_src_model vsc_src_model_inst (.clock_in(clock_in), .hsync_n_out(hs_n), .vsync_out(vs),
    .clamp_pin_out(cl_pin), .coast_pin_out(co_pin));
  vsc_top vsc_top_inst (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .horizontal_sync_input_0_in(hs_n), .vertical_sync_input_0_in(vs),
    .vertical_sync_input_1_in(vs1), .vsync_select_in(vsel), .clamp_pin_in(cl_pin),
    .coast_pin_in(co_pin), .power_down_pin_in(pd_pin), .sog_compare_in(sog),
    .hsync_pol_in(hpol), .vsync_pol_in(vpol), .clamp_pol_in(cl_pol),
    .coast_pol_in(co_pol), .clamp_ext_en_in(cl_ext), .ext_clock_en_in(ext_en),
    .manual_pd_en_in(man_pd), .pd_pin_active_high_in(pd_ah), .sog_threshold_in(thr),
    .clamp_delay_in(cdel), .clamp_width_in(cwid), .clamp_out(clamp_o), .coast_out(coast_o),
    .ext_clock_sel_out(ext_o), .power_down_out(pd_o), .sync_slicer_output_out(slice_o),
    .sog_threshold_out(thr_o), .field_odd_out(field_o), .vsync_leading_out(lead_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // the source model sends 16 lines a frame, one internal clamp pulse per line
  function automatic logic [15:0] clamp_cycles(input logic [15:0] w);
    return 16'h10 * w;
  endfunction
  function automatic logic [4:0] thr_code(input int mv);
    return 5'((mv - 8) / 8);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
    forever #12.5 clock_in = ~clock_in;
  initial
  begin
    #400us;
    err_total++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(negedge clock_in);
    check(16'(thr_o), 16'(thr_code(128)));
    check(16'({clamp_o, coast_o, ext_o, pd_o, slice_o, field_o, lead_o}), 16'h0);
    rst_in = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      {ext_en, sog, pd_pin, pd_ah, man_pd, vs1} = rnd[5:0];
      thr = (i < 2) ? 5'h1F * 5'(i) : rnd[10:6];
      if (i == 2)
        {man_pd, pd_ah, pd_pin} = 3'h6;
      repeat (8) @(negedge clock_in);
      check(16'(ext_o), 16'(ext_en));
      check(16'(slice_o), 16'(sog));
      check(16'(pd_o), 16'(man_pd && pd_pin == pd_ah));
      check(16'(thr_o), 16'(thr));
    end
    // a frozen clock enable must hold the registered select
    clk_en_in = 1'b0;
    ext_en = !ext_en;
    repeat (4) @(negedge clock_in);
    check(16'(ext_o), 16'(!ext_en));
    clk_en_in = 1'b1;
    for (int r = 0; r < 5; r++)
    begin
      {cl_ext, cl_pol, co_pol} = rows[r];
      // last pass: rising hsync edge leads, second vsync pin, random timer settings
      if (r == 4)
      begin
        rnd = lfsr(rnd);
        hpol = vsc_pkg::POL_HIGH;
        vpol = vsc_pkg::POL_LOW;
        vsel = 1'b1;
        cdel = 16'(rnd[3:0]);
        cwid = 16'(rnd[6:4]) + 16'h1;
      end
      c_cl = 0;
      c_co = 0;
      for (int n = 0; n < 2048; n++)
      begin
        @(negedge clock_in);
        vs1 = !vs;
        if (n == 1023)
          f0 = field_o;
        if (n >= 1024)
        begin
          c_cl += clamp_o;
          c_co += coast_o;
        end
      end
      check(16'(c_cl), (r == 4) ? clamp_cycles(cwid) : exp_cl[r[1:0]]);
      check(16'(c_co), exp_co[r]);
      check(16'(field_o), 16'(!f0));
    end
    finish_test;
  end
endmodule
